// ### include/sto_chan_if.sv
// filtered level of one safety channel, passed from its filter to the core
`timescale 1ns/1ps
interface sto_chan_if;
  logic off_level;
  modport filt (output off_level);
  modport core (input off_level);
endinterface // sto_chan_if

// ### include/sto_pkg.sv
// constants, register map and types of the safe torque off interlock
package sto_pkg;
  localparam int CLK_HZ           = 25_000_000;
  localparam int FILTER_TIME_US   = 500;
  localparam int FILTER_CYCLES    = FILTER_TIME_US * (CLK_HZ / 1_000_000);
  localparam int MS_TIME_US       = 1000;
  localparam int MS_CYCLES        = MS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int MISMATCH_TIME_MS = 10_000;
  localparam int RESPONSE_TIME_MS = 20;

  localparam logic [11:0] CMD_OFFSET    = 12'h000;
  localparam logic [11:0] CFG_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  localparam int CMD_SERVO_ON_BIT    = 0;
  localparam int CMD_ALARM_RESET_BIT = 2;
  localparam int CMD_UTIL_CANCEL_BIT = 3;

  localparam int CFG_DB_ENABLE_BIT   = 0;
  localparam int CFG_UTIL_ACTIVE_BIT = 1;
  localparam int CFG_DELAY_LSB       = 16;
  localparam int CFG_DELAY_W         = 16;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0001;

  typedef enum logic [1:0] {
    sto_st_base_blocked = 2'b00,
    sto_st_running      = 2'b01,
    sto_st_hw_blocked   = 2'b10
  } sto_state_type;
endpackage

// ### rtl/sto_input_filter.sv
// synchroniser and short off-pulse rejection for one safety channel
`timescale 1ns/1ps
module sto_input_filter #(
  parameter int CYCLES = sto_pkg::FILTER_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin_n,
  sto_chan_if.filt  chan
);
  import sto_pkg::*;

  logic        sync1_reg;
  logic        sync2_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        off_reg;
  logic        off_next;

  // off must last longer than the limit; on is taken at once
  always_comb begin
    cnt_next = cnt_reg;
    off_next = off_reg;
    if (!sync2_reg) begin
      cnt_next = 16'h0000;
      off_next = 1'b0;
    end else if (cnt_reg >= 16'(CYCLES)) begin
      off_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // resets to off so the drive starts blocked
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      cnt_reg   <= 16'h0000;
      off_reg   <= 1'b1;
    end else begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
      cnt_reg   <= cnt_next;
      off_reg   <= off_next;
    end
  end

  assign chan.off_level = off_reg;
endmodule // sto_input_filter

// ### rtl/sto_interlock.sv
// dual-channel safe torque off interlock with apb control registers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module sto_interlock #(
  parameter int FILTER_CYCLES = sto_pkg::FILTER_CYCLES,
  parameter int MS_CYCLES     = sto_pkg::MS_CYCLES,
  parameter int MISMATCH_MS   = sto_pkg::MISMATCH_TIME_MS
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        safety_in_a_n,
  input  wire logic        safety_in_b_n,
  input  wire logic        main_power_ok,
  output logic             motor_power_en,
  output logic             brake_release_out,
  output logic             dyn_brake_out,
  output logic             safety_monitor_out,
  output logic             dual_channel_timing_alarm
);
  import sto_pkg::*;

  sto_chan_if chan_a ();
  sto_chan_if chan_b ();
  logic       ms_tick;

  sto_input_filter #(.CYCLES(FILTER_CYCLES)) u_filter_a (
    .clock (clock),
    .rst   (rst),
    .pin_n (safety_in_a_n),
    .chan  (chan_a)
  );
  sto_input_filter #(.CYCLES(FILTER_CYCLES)) u_filter_b (
    .clock (clock),
    .rst   (rst),
    .pin_n (safety_in_b_n),
    .chan  (chan_b)
  );
  sto_tick_div #(.DIV(MS_CYCLES)) u_ms_div (
    .clock (clock),
    .rst   (rst),
    .tick  (ms_tick)
  );

  sto_state_type state_reg;
  sto_state_type state_next;
  logic [31:0]   cfg_reg;
  logic [31:0]   cfg_next;
  logic [31:0]   prdata_reg;
  logic [31:0]   prdata_next;
  logic          son_pend_reg;
  logic          son_pend_next;
  logic          util_lock_reg;
  logic          util_lock_next;
  logic          power_reg;
  logic          power_next;
  logic          brake_reg;
  logic          brake_next;
  logic [15:0]   brake_cnt_reg;
  logic [15:0]   brake_cnt_next;
  logic          dyn_reg;
  logic          dyn_next;
  logic          monitor_reg;
  logic          monitor_next;
  logic [13:0]   mm_cnt_reg;
  logic [13:0]   mm_cnt_next;
  logic          alarm_reg;
  logic          alarm_next;

  logic          off_a;
  logic          off_b;
  logic          blocked;
  logic          mismatch;
  logic          access;
  logic          mapped;
  logic          cmd_write;
  logic          cmd_son;
  logic          cmd_other;
  logic          alarm_clr;
  logic          util_cancel;
  logic          util_active;
  logic [31:0]   status_word;

  assign off_a       = chan_a.off_level;
  assign off_b       = chan_b.off_level;
  assign blocked     = off_a | off_b;
  assign mismatch    = off_a ^ off_b;
  assign access      = psel & penable;
  assign mapped      = (paddr == CMD_OFFSET) | (paddr == CFG_OFFSET)
                       | (paddr == STATUS_OFFSET);
  assign cmd_write   = access & pwrite & (paddr == CMD_OFFSET);
  assign cmd_son     = cmd_write & pwdata[CMD_SERVO_ON_BIT];
  // any command word without servo on counts as servo off or other
  assign cmd_other   = cmd_write & ~pwdata[CMD_SERVO_ON_BIT];
  assign alarm_clr   = cmd_write & pwdata[CMD_ALARM_RESET_BIT];
  assign util_cancel = cmd_write & pwdata[CMD_UTIL_CANCEL_BIT];
  assign util_active = cfg_reg[CFG_UTIL_ACTIVE_BIT];

  assign status_word = {20'h00000, main_power_ok, son_pend_reg, util_lock_reg, dyn_reg,
                        brake_reg, power_reg, alarm_reg, monitor_reg, off_b, off_a,
                        state_reg};

  always_comb begin
    state_next     = state_reg;
    son_pend_next  = son_pend_reg;
    cfg_next       = cfg_reg;
    prdata_next    = prdata_reg;
    brake_cnt_next = brake_cnt_reg;
    brake_next     = brake_reg;
    mm_cnt_next    = mm_cnt_reg;

    // read data is caught in the setup cycle so pready can stay high
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        CFG_OFFSET:    prdata_next = cfg_reg;
        STATUS_OFFSET: prdata_next = status_word;
        default:       prdata_next = 32'h0000_0000;
      endcase
    end
    if (access & pwrite & (paddr == CFG_OFFSET)) begin
      cfg_next = pwdata;
    end

    // utility mode grants no exemption; a utility caught by blocking stays locked
    util_lock_next = (blocked & util_active) | (util_lock_reg & ~util_cancel);

    unique case (state_reg)
      sto_st_base_blocked: begin
        if (blocked) begin
          state_next = sto_st_hw_blocked;
        end else if (cmd_son & ~util_lock_reg) begin
          state_next = sto_st_running;
        end
      end
      sto_st_running: begin
        if (blocked) begin
          state_next = sto_st_hw_blocked;
        end else if (cmd_other) begin
          state_next = sto_st_base_blocked;
        end
      end
      sto_st_hw_blocked: begin
        // main power is not looked at: only commands leave this state
        if (blocked) begin
          son_pend_next = son_pend_reg | cmd_son;
        end else if (cmd_other) begin
          state_next    = sto_st_base_blocked;
          son_pend_next = 1'b0;
        end else if (cmd_son & ~son_pend_reg & ~util_lock_reg) begin
          state_next = sto_st_running;
        end else if (cmd_son) begin
          son_pend_next = 1'b1;
        end
      end
      default: begin
        state_next = sto_st_hw_blocked;
      end
    endcase

    power_next   = (state_next == sto_st_running);
    dyn_next     = (state_next == sto_st_hw_blocked) & cfg_reg[CFG_DB_ENABLE_BIT];
    monitor_next = off_a & off_b;

    // brake holds for the set delay after servo off, but never after blocking
    if (blocked) begin
      brake_next     = 1'b0;
      brake_cnt_next = 16'h0000;
    end else if (state_next == sto_st_running) begin
      brake_next     = 1'b1;
      brake_cnt_next = cfg_reg[CFG_DELAY_LSB +: CFG_DELAY_W];
    end else if (brake_cnt_reg == 16'h0000) begin
      brake_next = 1'b0;
    end else if (ms_tick) begin
      brake_cnt_next = brake_cnt_reg - 16'h0001;
    end

    // one extra tick makes the wait at least the full time despite tick phase
    if (!mismatch) begin
      mm_cnt_next = 14'h0000;
    end else if (ms_tick & (mm_cnt_reg < 14'(MISMATCH_MS))) begin
      mm_cnt_next = mm_cnt_reg + 14'h0001;
    end
    alarm_next = (mismatch & ms_tick & (mm_cnt_reg == 14'(MISMATCH_MS)))
                 | (alarm_reg & ~alarm_clr);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg     <= sto_st_hw_blocked;
      cfg_reg       <= CFG_RESET;
      prdata_reg    <= 32'h0000_0000;
      son_pend_reg  <= 1'b0;
      util_lock_reg <= 1'b0;
      power_reg     <= 1'b0;
      brake_reg     <= 1'b0;
      brake_cnt_reg <= 16'h0000;
      dyn_reg       <= 1'b0;
      monitor_reg   <= 1'b0;
      mm_cnt_reg    <= 14'h0000;
      alarm_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cfg_reg       <= cfg_next;
      prdata_reg    <= prdata_next;
      son_pend_reg  <= son_pend_next;
      util_lock_reg <= util_lock_next;
      power_reg     <= power_next;
      brake_reg     <= brake_next;
      brake_cnt_reg <= brake_cnt_next;
      dyn_reg       <= dyn_next;
      monitor_reg   <= monitor_next;
      mm_cnt_reg    <= mm_cnt_next;
      alarm_reg     <= alarm_next;
    end
  end

  assign prdata                    = prdata_reg;
  assign pready                    = 1'b1;
  assign pslverr                   = access & ~mapped;
  assign motor_power_en            = power_reg;
  assign brake_release_out         = brake_reg;
  assign dyn_brake_out             = dyn_reg;
  assign safety_monitor_out        = monitor_reg;
  assign dual_channel_timing_alarm = alarm_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_power_cut_block: assert property (blocked |=> !motor_power_en)
    else $error("motor power stayed on while blocked");
  a_block_enters_hw: assert property (blocked |=> state_reg == sto_st_hw_blocked)
    else $error("blocking did not enter the blocked state");
  a_brake_drop_now: assert property (blocked |=> !brake_release_out)
    else $error("brake release not dropped at blocking");
  a_dyn_brake_on: assert property (
      blocked && cfg_reg[CFG_DB_ENABLE_BIT] |=> dyn_brake_out)
    else $error("dynamic brake not applied when blocked");
  a_monitor_follow: assert property (
      (off_a && off_b) != $past(off_a && off_b) |=> safety_monitor_out == $past(off_a && off_b))
    else $error("monitor output does not follow both inputs");
  // power is registered at the same edge as the state
  a_resume_on_son: assert property (
      state_reg == sto_st_hw_blocked && !blocked && cmd_son && !son_pend_reg
      && !util_lock_reg |=> state_reg == sto_st_running && motor_power_en)
    else $error("servo on did not resume from blocked state");
  a_pending_son_held: assert property (
      state_reg == sto_st_hw_blocked && son_pend_reg && !cmd_other
      |=> state_reg == sto_st_hw_blocked)
    else $error("stale servo on left the blocked state");
  a_other_to_base: assert property (
      state_reg == sto_st_hw_blocked && !blocked && cmd_other
      |=> state_reg == sto_st_base_blocked && !son_pend_reg)
    else $error("non servo on command did not reach base block");
  a_alarm_latched: assert property (
      dual_channel_timing_alarm && !alarm_clr |=> dual_channel_timing_alarm)
    else $error("timing alarm dropped without reset");
  a_alarm_needs_time: assert property (
      $rose(dual_channel_timing_alarm) |-> $past(mismatch) && $past(mm_cnt_reg) == 14'(MISMATCH_MS))
    else $error("timing alarm raised before the mismatch time");
  a_util_locked: assert property (
      util_lock_reg && !util_cancel |=> state_reg != sto_st_running)
    else $error("locked utility allowed resume");

  c_run_to_block: cover property (state_reg == sto_st_running ##1 state_reg == sto_st_hw_blocked);
  c_block_resume: cover property (state_reg == sto_st_hw_blocked ##1 state_reg == sto_st_running);
  c_block_to_base: cover property (
      state_reg == sto_st_hw_blocked ##1 state_reg == sto_st_base_blocked);
  c_alarm_raised: cover property ($rose(dual_channel_timing_alarm));
endmodule // sto_interlock

// ### rtl/sto_tick_div.sv
// divider giving a one-cycle enable pulse every div clock cycles
`timescale 1ns/1ps
module sto_tick_div #(
  parameter int DIV = sto_pkg::MS_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  output logic      tick
);
  import sto_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 16'h0001;
    if (cnt_reg >= 16'(DIV - 1)) begin
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // sto_tick_div

// ### verification/sto_interlock_test.sv
// self-checking bench of the safe torque off interlock
`timescale 1ns/1ps
module sto_interlock_test;
  import sto_pkg::*;
  localparam int O_PWR = 0, O_BRK = 1, O_DYN = 2, O_MON = 3, O_ALM = 4;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, main_power_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        off_a, off_b, pin_a, pin_b, mon_fault, err;
  logic        motor_power_en, brake_release_out, dyn_brake_out;
  logic        safety_monitor_out, dual_channel_timing_alarm;
  wire  [4:0]  outs = {dual_channel_timing_alarm, safety_monitor_out, dyn_brake_out,
                       brake_release_out, motor_power_en};
  int          bad_count = 0, num_checks = 0;

  sto_interlock #(.FILTER_CYCLES(20), .MS_CYCLES(10), .MISMATCH_MS(5)) dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safety_in_a_n(pin_a), .safety_in_b_n(pin_b), .main_power_ok(main_power_ok),
    .motor_power_en(motor_power_en), .brake_release_out(brake_release_out),
    .dyn_brake_out(dyn_brake_out), .safety_monitor_out(safety_monitor_out),
    .dual_channel_timing_alarm(dual_channel_timing_alarm));
  sto_safety_unit unit (.clock(clock), .rst(rst), .req_off_a(off_a), .req_off_b(off_b),
    .safety_monitor_out(safety_monitor_out), .safety_in_a_n(pin_a),
    .safety_in_b_n(pin_b), .monitor_fault(mon_fault));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk1(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b", $time, msg, got);
    end
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask

  // one transfer; request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("unexpected at %0t: bus answer wait ran out", $time);
      end_of_test();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task state_is(input sto_state_type s);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk32({30'h0, rd[1:0]}, {30'h0, s}, "state");
  endtask

  task wait_out(input int idx, input logic v, input int bound);
    int n;
    n = 0;
    while (outs[idx] !== v && n < bound) begin
      @(posedge clock);
      n++;
    end
    if (n >= bound) begin
      bad_count++;
      $display("unexpected at %0t: output %0d wait ran out", $time, idx);
      end_of_test();
    end
  endtask

  task test_reset;
    state_is(sto_st_hw_blocked);
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk32(rd, CFG_RESET, "cfg reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk1(err, 1'b1, "unmapped error");
    chk32(rd, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  task test_start;
    apb(1'b1, CMD_OFFSET, 32'h0);
    state_is(sto_st_base_blocked);
    apb(1'b1, CFG_OFFSET, 32'h0003_0001);
    apb(1'b1, CMD_OFFSET, 32'h1);
    state_is(sto_st_running);
    chk1(motor_power_en, 1'b1, "power on");
    chk1(brake_release_out, 1'b1, "brake released");
    $display("test start done");
  endtask

  task test_glitch;
    off_a <= 1'b1;
    repeat (10) @(posedge clock);
    off_a <= 1'b0;
    repeat (40) begin
      @(posedge clock);
      chk1(motor_power_en, 1'b1, "short pulse kept power");
    end
    $display("test glitch done");
  endtask

  task test_single;
    off_a <= 1'b1;
    wait_out(O_PWR, 1'b0, 30);
    chk1(brake_release_out, 1'b0, "brake dropped without delay");
    chk1(dyn_brake_out, 1'b1, "dynamic brake");
    chk1(safety_monitor_out, 1'b0, "monitor one off");
    wait_out(O_ALM, 1'b1, 120);
    main_power_ok <= 1'b0;
    apb(1'b1, CMD_OFFSET, 32'h1);
    off_a <= 1'b0;
    repeat (30) @(posedge clock);
    state_is(sto_st_hw_blocked);
    main_power_ok <= 1'b1;
    apb(1'b1, CMD_OFFSET, 32'h1);
    state_is(sto_st_hw_blocked);
    chk1(dual_channel_timing_alarm, 1'b1, "alarm latched");
    apb(1'b1, CMD_OFFSET, 32'h4);
    state_is(sto_st_base_blocked);
    chk1(dual_channel_timing_alarm, 1'b0, "alarm reset");
    apb(1'b1, CMD_OFFSET, 32'h1);
    state_is(sto_st_running);
    $display("test single done");
  endtask

  task test_both;
    apb(1'b1, CMD_OFFSET, 32'h0);
    state_is(sto_st_base_blocked);
    off_a <= 1'b1;
    off_b <= 1'b1;
    wait_out(O_MON, 1'b1, 30);
    chk1(motor_power_en, 1'b0, "power off both");
    repeat (80) @(posedge clock);
    chk1(dual_channel_timing_alarm, 1'b0, "no alarm when agreeing");
    chk1(mon_fault, 1'b0, "monitor matches pins");
    off_a <= 1'b0;
    off_b <= 1'b0;
    wait_out(O_MON, 1'b0, 30);
    apb(1'b1, CMD_OFFSET, 32'h0);
    apb(1'b1, CMD_OFFSET, 32'h1);
    state_is(sto_st_running);
    $display("test both done");
  endtask

  task test_util;
    apb(1'b1, CFG_OFFSET, 32'h0000_0002);
    off_b <= 1'b1;
    wait_out(O_PWR, 1'b0, 30);
    chk1(dyn_brake_out, 1'b0, "dynamic brake disabled");
    off_b <= 1'b0;
    repeat (30) @(posedge clock);
    apb(1'b1, CFG_OFFSET, 32'h0);
    apb(1'b1, CMD_OFFSET, 32'h0);
    apb(1'b1, CMD_OFFSET, 32'h1);
    state_is(sto_st_base_blocked);
    apb(1'b1, CMD_OFFSET, 32'h8);
    apb(1'b1, CMD_OFFSET, 32'h1);
    state_is(sto_st_running);
    chk1(mon_fault, 1'b0, "monitor still matches");
    $display("test util done");
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, off_a, off_b} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    main_power_ok = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_start();
    test_glitch();
    test_single();
    test_both();
    test_util();
    end_of_test();
  end
endmodule // sto_interlock_test

// ### verification/sto_safety_unit.sv
// behavioural safety unit driving the two channels and watching the monitor
`timescale 1ns/1ps
module sto_safety_unit (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic req_off_a,
  input  wire logic req_off_b,
  input  wire logic safety_monitor_out,
  output logic      safety_in_a_n,
  output logic      safety_in_b_n,
  output logic      monitor_fault
);
  logic [5:0] stable_cnt;
  // two separate drivers, so one stuck contact cannot hold both channels
  always_ff @(posedge clock) begin
    if (rst) begin
      safety_in_a_n <= 1'b1;
      safety_in_b_n <= 1'b1;
      stable_cnt    <= 6'h00;
      monitor_fault <= 1'b0;
    end else begin
      safety_in_a_n <= req_off_a;
      safety_in_b_n <= req_off_b;
      if (req_off_a != safety_in_a_n || req_off_b != safety_in_b_n)
        stable_cnt <= 6'h00;
      else if (stable_cnt != 6'h3f)
        stable_cnt <= stable_cnt + 6'h01;
      // judged only once the pins have settled longer than the response time
      if (stable_cnt == 6'h3f && safety_monitor_out != (safety_in_a_n & safety_in_b_n))
        monitor_fault <= 1'b1;
    end
  end
endmodule // sto_safety_unit
